// file: core/peripheral_irq_enable_flag_bank.sv
// peripheral interrupt enable and request flag bank with apb access
//
// Summary of operation
// - first enable register, one bit per source
// - second enable register, one bit per source
// - second registers bit four reads zero always
// - flags set regardless of enable or disable
// - first flag register mirrors first enable layout
// - port change flag held while mismatch remains
// - timer3 flag source chosen by capture1 mode
// - timer2 flag sets on period rollover
// - timer1 flag source chosen by wide mode
// - capture flags set on their capture events
// - usart transmit flags follow empty, reset one
// - usart receive flags follow full, reset zero
// - serial flag sets on transfer completion
// - i2c master conditions also set serial flag
// - collision flag sets in i2c master mode
// - conversion flag sets when conversion finishes
// - pending equals or of flags and enables
// - group enable gates pending onto core request
// - vector entry leaves every flag unchanged
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "irq_bank_defines.svh"

module peripheral_irq_enable_flag_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] portb_pins,
    input wire logic timer3_overflow,
    input wire logic timer3_period_wrap,
    input wire logic timer2_period_wrap,
    input wire logic timer1_period_wrap,
    input wire logic timer21_period_wrap,
    input wire logic [3:0] capture_event,
    input wire logic usart1_tx_empty,
    input wire logic usart1_rx_full,
    input wire logic usart2_tx_empty,
    input wire logic usart2_rx_full,
    input wire logic sp_xfer_done,
    input wire logic sp_master_cond_done,
    input wire logic sp_idle_bus_cond,
    input wire logic sp_i2c_master,
    input wire logic sp_bus_collision,
    input wire logic conversion_done,
    output logic capture1_mode_select,
    output logic wide_timer_mode,
    output logic peripheral_pending,
    output logic peripheral_irq
);

    // ========================================================
    // address decode
    function automatic irq_bank_pkg::reg_sel_t decode(
        input logic [7:0] addr
    );
        irq_bank_pkg::reg_sel_t sel;
        sel = irq_bank_pkg::SEL_NONE;
        if (addr[1:0] != 2'h0) begin
            sel = irq_bank_pkg::SEL_NONE;
        end else if (addr[7:2] == `IDX_FLAGS1) begin
            sel = irq_bank_pkg::SEL_FLAGS1;
        end else if (addr[7:2] == `IDX_ENABLES1) begin
            sel = irq_bank_pkg::SEL_ENABLES1;
        end else if (addr[7:2] == `IDX_FLAGS2) begin
            sel = irq_bank_pkg::SEL_FLAGS2;
        end else if (addr[7:2] == `IDX_ENABLES2) begin
            sel = irq_bank_pkg::SEL_ENABLES2;
        end else if (addr[7:2] == `IDX_CONTROL) begin
            sel = irq_bank_pkg::SEL_CONTROL;
        end else if (addr[7:2] == `IDX_PORTB_SNAP) begin
            sel = irq_bank_pkg::SEL_PORTB_SNAP;
        end
        return sel;
    endfunction

    irq_bank_pkg::reg_sel_t sel;
    logic access;
    logic done;
    logic wr_fire;
    logic rd_fire;
    logic lane0;
    irq_bank_pkg::byte_t wbyte;

    irq_bank_pkg::byte_t flags1_q;
    irq_bank_pkg::byte_t flags1_d;
    irq_bank_pkg::byte_t flags2_q;
    irq_bank_pkg::byte_t flags2_d;
    irq_bank_pkg::byte_t enables1_q;
    irq_bank_pkg::byte_t enables1_d;
    irq_bank_pkg::byte_t enables2_q;
    irq_bank_pkg::byte_t enables2_d;
    logic [2:0] control_q;
    logic [2:0] control_d;
    irq_bank_pkg::byte_t set1;
    irq_bank_pkg::byte_t set2;
    irq_bank_pkg::byte_t rdata;
    logic pending_d;

    logic [7:0] pin_s1_q;
    logic [7:0] pin_s2_q;
    logic [7:0] pin_s3_q;
    logic [7:0] pin_stable_q;
    logic [7:0] pin_latch_q;
    logic mismatch;

    logic ready_q;
    logic slverr_q;
    logic [31:0] rdata_q;
    logic pending_q;
    logic irq_q;

    assign sel = decode(paddr);
    assign access = psel && penable;
    // one wait state: answer on the second access cycle
    assign done = access && ready_q;
    assign lane0 = pstrb[0];
    assign wbyte = pwdata[7:0];
    assign wr_fire = done && pwrite && lane0 && !slverr_q;
    assign rd_fire = done && !pwrite && !slverr_q;

    // ========================================================
    // port pin synchroniser and mismatch detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_q <= `BYTE_ZERO;
            pin_s2_q <= `BYTE_ZERO;
            pin_s3_q <= `BYTE_ZERO;
        end else if (clk_en) begin
            pin_s1_q <= portb_pins;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // a pin bit counts as changed only once two stages agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_stable_q <= `BYTE_ZERO;
        end else if (clk_en) begin
            for (int i = 0; i < 8; i++) begin
                if (pin_s2_q[i] == pin_s3_q[i]) begin
                    pin_stable_q[i] <= pin_s3_q[i];
                end
            end
        end
    end

    // reading the snapshot register ends the mismatch; the latch takes
    // the value software was handed, so a pin change in the wait state
    // is not lost but keeps the mismatch alive
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_latch_q <= `BYTE_ZERO;
        end else if (clk_en) begin
            if (rd_fire && sel == irq_bank_pkg::SEL_PORTB_SNAP) begin
                pin_latch_q <= rdata_q[7:0];
            end
        end
    end

    // flag keeps setting until software removes the mismatch
    assign mismatch = pin_stable_q != pin_latch_q;

    // ========================================================
    // hardware set conditions
    always_comb begin
        set1 = `BYTE_ZERO;
        set2 = `BYTE_ZERO;
        set1[`B1_PORTB] = mismatch;
        set1[`B1_TIMER3] = control_q[`BC_CAP1_MODE] ?
            timer3_overflow : timer3_period_wrap;
        set1[`B1_TIMER2] = timer2_period_wrap;
        set1[`B1_TIMER1] = control_q[`BC_WIDE_TIMER] ?
            timer21_period_wrap : timer1_period_wrap;
        set1[`B1_CAPTURE2] = capture_event[1];
        set1[`B1_CAPTURE1] = capture_event[0];
        set2[`B2_SERIAL] = sp_xfer_done ||
            (sp_i2c_master && (sp_master_cond_done ||
            sp_idle_bus_cond));
        set2[`B2_COLLISION] = sp_bus_collision &&
            sp_i2c_master;
        set2[`B2_CONVERSION] = conversion_done;
        set2[`B2_CAPTURE4] = capture_event[3];
        set2[`B2_CAPTURE3] = capture_event[2];
    end

    // ========================================================
    // flag next state
    // no vector acknowledge input exists: flags change only by
    // events and software writes
    always_comb begin
        flags1_d = flags1_q & `FLAGS1_RW_MASK;
        if (wr_fire && sel == irq_bank_pkg::SEL_FLAGS1) begin
            flags1_d = wbyte & `FLAGS1_RW_MASK;
        end
        // set wins over a clearing write; enables are not looked at
        flags1_d = flags1_d | set1;
        flags1_d[`B1_USART1_TX] = usart1_tx_empty;
        flags1_d[`B1_USART1_RX] = usart1_rx_full;
    end

    always_comb begin
        flags2_d = flags2_q & `FLAGS2_RW_MASK;
        if (wr_fire && sel == irq_bank_pkg::SEL_FLAGS2) begin
            flags2_d = wbyte & `FLAGS2_RW_MASK;
        end
        flags2_d = flags2_d | set2;
        flags2_d[`B2_USART2_TX] = usart2_tx_empty;
        flags2_d[`B2_USART2_RX] = usart2_rx_full;
    end

    // layout of the first flag register matches its enables
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags1_q <= `FLAGS1_RESET;
            flags2_q <= `FLAGS2_RESET;
        end else if (clk_en) begin
            flags1_q <= flags1_d;
            flags2_q <= flags2_d;
        end
    end

    // ========================================================
    // enables and control
    always_comb begin
        enables1_d = enables1_q;
        enables2_d = enables2_q;
        control_d = control_q;
        if (wr_fire && sel == irq_bank_pkg::SEL_ENABLES1) begin
            enables1_d = wbyte & `ENABLES1_MASK;
        end
        if (wr_fire && sel == irq_bank_pkg::SEL_ENABLES2) begin
            enables2_d = wbyte & `ENABLES2_MASK;
        end
        if (wr_fire && sel == irq_bank_pkg::SEL_CONTROL) begin
            control_d = wbyte[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enables1_q <= `ENABLES_RESET;
            enables2_q <= `ENABLES_RESET;
            control_q <= `CONTROL_RESET;
        end else if (clk_en) begin
            enables1_q <= enables1_d;
            enables2_q <= enables2_d;
            control_q <= control_d;
        end
    end

    // ========================================================
    // pending and core request
    // built from next state so the outputs track the registers
    // in the same cycle; a stale flag fires as soon as enabled,
    // which is why software should clear it first
    assign pending_d = |(flags1_d & enables1_d) ||
        |(flags2_d & enables2_d);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pending_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (clk_en) begin
            pending_q <= pending_d;
            irq_q <= pending_d && control_d[`BC_GROUP_EN];
        end
    end

    // ========================================================
    // apb read mux and answer
    always_comb begin
        rdata = `BYTE_ZERO;
        case (sel)
            irq_bank_pkg::SEL_FLAGS1: begin
                rdata = flags1_q;
            end
            irq_bank_pkg::SEL_FLAGS2: begin
                rdata = flags2_q;
            end
            irq_bank_pkg::SEL_ENABLES1: begin
                rdata = enables1_q;
            end
            irq_bank_pkg::SEL_ENABLES2: begin
                rdata = enables2_q;
            end
            irq_bank_pkg::SEL_CONTROL: begin
                rdata[2:0] = control_q;
                rdata[`BC_PENDING] = pending_q;
            end
            irq_bank_pkg::SEL_PORTB_SNAP: begin
                rdata = pin_stable_q;
            end
            default: begin
                rdata = `BYTE_ZERO;
            end
        endcase
    end

    // ready rises on the first access cycle's edge and falls after
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
            slverr_q <= 1'b0;
            rdata_q <= 32'h0;
        end else if (clk_en) begin
            if (access && !ready_q) begin
                ready_q <= 1'b1;
                slverr_q <= sel == irq_bank_pkg::SEL_NONE;
                rdata_q <= {24'h0, rdata};
            end else begin
                ready_q <= 1'b0;
                slverr_q <= 1'b0;
            end
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = slverr_q;
    assign capture1_mode_select = control_q[`BC_CAP1_MODE];
    assign wide_timer_mode = control_q[`BC_WIDE_TIMER];
    assign peripheral_pending = pending_q;
    assign peripheral_irq = irq_q;

endmodule

`default_nettype wire

// file: shared/irq_bank_defines.svh
// constants for the peripheral interrupt enable and flag bank
`ifndef IRQ_BANK_DEFINES_SVH
`define IRQ_BANK_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_FLAGS2 6'h10
`define IDX_ENABLES2 6'h11
`define IDX_FLAGS1 6'h16
`define IDX_ENABLES1 6'h17
`define IDX_CONTROL 6'h18
`define IDX_PORTB_SNAP 6'h19

// first flag / enable register bit positions
`define B1_PORTB 7
`define B1_TIMER3 6
`define B1_TIMER2 5
`define B1_TIMER1 4
`define B1_CAPTURE2 3
`define B1_CAPTURE1 2
`define B1_USART1_TX 1
`define B1_USART1_RX 0

// second flag / enable register bit positions
`define B2_SERIAL 7
`define B2_COLLISION 6
`define B2_CONVERSION 5
`define B2_CAPTURE4 3
`define B2_CAPTURE3 2
`define B2_USART2_TX 1
`define B2_USART2_RX 0

// control register bit positions
`define BC_GROUP_EN 0
`define BC_CAP1_MODE 1
`define BC_WIDE_TIMER 2
`define BC_PENDING 7

// masks of bits that software may write
`define FLAGS1_RW_MASK 8'hfc
`define FLAGS2_RW_MASK 8'hec
`define ENABLES1_MASK 8'hff
`define ENABLES2_MASK 8'hef

// reset values
`define FLAGS1_RESET 8'h02
`define FLAGS2_RESET 8'h02
`define ENABLES_RESET 8'h00
`define CONTROL_RESET 3'h0
`define BYTE_ZERO 8'h00

`endif

// file: shared/irq_bank_pkg.sv
// types shared by the peripheral interrupt enable and flag bank
`default_nettype none
package irq_bank_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_FLAGS1 = 3'h1,
        SEL_ENABLES1 = 3'h3,
        SEL_FLAGS2 = 3'h2,
        SEL_ENABLES2 = 3'h6,
        SEL_CONTROL = 3'h7,
        SEL_PORTB_SNAP = 3'h5
    } reg_sel_t;

endpackage

`default_nettype wire

// file: testbench/event_source_model.sv
// event source model: one-cycle strobes from timers, captures, serial port, a/d
`timescale 1ns/1ns
`default_nettype none
module event_source_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] sel,
    output logic [13:0] pulse
);
    // sources report each event as a single strobe on the core clock
    always_ff @(posedge clk) begin
        pulse <= go ? (14'h0001 << sel) : 14'h0000;
    end
endmodule
`default_nettype wire

// file: testbench/irq_bank_checker_assertions.sv
// port-level assertions for the peripheral irq enable and flag bank
`timescale 1ns/1ns
`default_nettype none
module irq_bank_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic usart1_tx_empty,
    input wire logic usart1_rx_full,
    input wire logic usart2_tx_empty,
    input wire logic usart2_rx_full,
    input wire logic capture1_mode_select,
    input wire logic wide_timer_mode,
    input wire logic peripheral_pending,
    input wire logic peripheral_irq
);
    // ==========
    // helpers
    logic mapped;
    logic wr_done;
    logic usart_low;
    assign mapped = paddr inside {8'h40, 8'h44, 8'h58, 8'h5c, 8'h60, 8'h64};
    assign wr_done = psel && penable && pready && pwrite;
    assign usart_low = !usart1_tx_empty || !usart1_rx_full ||
        !usart2_tx_empty || !usart2_rx_full;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_good;
        psel && !penable && mapped;
    endsequence
    sequence s_bad;
        psel && !penable && !mapped;
    endsequence
    // ==========
    // properties
    AST_ONE_WAIT: assert property (
        s_good ##1 s_access |=> pready && !pslverr)
        else $error("mapped access not answered after one wait");
    AST_BAD_ADDR: assert property (
        s_bad ##1 s_access |=> pready && pslverr)
        else $error("unmapped access not refused");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    AST_IRQ_GATED: assert property (
        peripheral_irq |-> peripheral_pending)
        else $error("core request without pending");
    AST_NO_SELF_CLEAR: assert property ($fell(peripheral_pending) |->
        $past(wr_done) || $past(usart_low))
        else $error("pending dropped without software or usart cause");
    AST_MODE_HOLD: assert property ($changed(capture1_mode_select) |->
        $past(wr_done && paddr == 8'h60))
        else $error("capture1 mode changed without control write");
    AST_WIDE_HOLD: assert property ($changed(wide_timer_mode) |->
        $past(wr_done && paddr == 8'h60))
        else $error("wide mode changed without control write");
endmodule
bind peripheral_irq_enable_flag_bank irq_bank_checker chk_u (.clk, .rst_n,
    .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .usart1_tx_empty, .usart1_rx_full, .usart2_tx_empty, .usart2_rx_full,
    .capture1_mode_select, .wide_timer_mode, .peripheral_pending,
    .peripheral_irq);
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the peripheral irq enable and flag bank
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, pins = 8'h00, rd;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, err, go = 0, mst = 0;
    logic tx1 = 1, rx1 = 0, tx2 = 1, rx2 = 0;
    logic [3:0] sel = 4'h0;
    logic [13:0] p;
    logic cap1_mode, wide, pend, irq;
    int n_mismatch = 0, num_checks = 0;
    peripheral_irq_enable_flag_bank dut_u (
        .clk, .rst_n, .clk_en(1'b1), .paddr, .psel, .penable, .pwrite,
        .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
        .portb_pins(pins), .timer3_overflow(p[0]), .timer3_period_wrap(p[1]),
        .timer2_period_wrap(p[2]), .timer1_period_wrap(p[3]),
        .timer21_period_wrap(p[4]), .capture_event(p[8:5]),
        .usart1_tx_empty(tx1), .usart1_rx_full(rx1),
        .usart2_tx_empty(tx2), .usart2_rx_full(rx2),
        .sp_xfer_done(p[9]), .sp_master_cond_done(p[10]),
        .sp_idle_bus_cond(p[11]), .sp_i2c_master(mst),
        .sp_bus_collision(p[12]), .conversion_done(p[13]),
        .capture1_mode_select(cap1_mode), .wide_timer_mode(wide),
        .peripheral_pending(pend), .peripheral_irq(irq)
    );
    event_source_model src_u (.clk, .go, .sel, .pulse(p));
    initial begin
        forever #10 clk = ~clk;
    end
    // ==========
    // shared tasks
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // the master holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                rd = prdata[7:0];
                err = pslverr;
                psel <= 1'b0;
                penable <= 1'b0;
                return;
            end
        end
        n_mismatch++;
        end_of_test();
    endtask
    task automatic rdc(input logic [7:0] a, e, input string nm);
        apb(1'b0, a, 8'h00);
        chk(nm, rd, e);
    endtask
    task automatic wrc(input logic [7:0] a, d, e, input string nm);
        apb(1'b1, a, d);
        rdc(a, e, nm);
    endtask
    task automatic bits(input logic pe, ie);
        chk("pending", {7'h0, pend}, {7'h0, pe});
        chk("core irq", {7'h0, irq}, {7'h0, ie});
    endtask
    task automatic fire(input int s);
        @(posedge clk);
        sel <= s[3:0];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // all enables are clear here, so every flag must still set
    task automatic ev(input int s, input logic [2:0] c, input logic m,
                      input logic [7:0] a, e);
        apb(1'b1, 8'h60, {5'h0, c});
        mst <= m;
        fire(s);
        chk("mode pins", {6'h0, wide, cap1_mode}, {6'h0, c[2:1]});
        rdc(a, e, "event flag");
        apb(1'b1, a, 8'h00);
    endtask
    // ==========
    // scenarios
    task automatic t_reset();
        rdc(8'h64, 8'h00, "snapshot");
        rdc(8'h58, 8'h02, "flags1");
        rdc(8'h40, 8'h02, "flags2");
        rdc(8'h5c, 8'h00, "enables1");
        rdc(8'h44, 8'h00, "enables2");
        $display("test reset done");
    endtask
    task automatic t_regs();
        wrc(8'h5c, 8'hff, 8'hff, "enables1");
        wrc(8'h44, 8'hff, 8'hef, "enables2");
        wrc(8'h40, 8'hff, 8'hee, "flags2 set");
        wrc(8'h58, 8'h7d, 8'h7e, "flags1 set");
        bits(1'b1, 1'b0);
        wrc(8'h40, 8'h00, 8'h02, "flags2 clear");
        wrc(8'h58, 8'h00, 8'h02, "flags1 clear");
        wrc(8'h44, 8'h00, 8'h00, "enables2 clear");
        apb(1'b0, 8'h68, 8'h00);
        chk("unmapped err", {7'h0, err}, 8'h01);
        apb(1'b1, 8'h5d, 8'h00);
        chk("misaligned err", {7'h0, err}, 8'h01);
        rdc(8'h5c, 8'hff, "refused write");
        wrc(8'h5c, 8'h00, 8'h00, "enables1 clear");
        $display("test registers done");
    endtask
    task automatic t_pend();
        wrc(8'h44, 8'h20, 8'h20, "enable after clear");
        apb(1'b1, 8'h60, 8'h01);
        fire(13);
        bits(1'b1, 1'b1);
        rdc(8'h60, 8'h81, "control");
        apb(1'b1, 8'h60, 8'h00);
        @(posedge clk);
        bits(1'b1, 1'b0);
        rdc(8'h40, 8'h22, "flag kept");
        apb(1'b1, 8'h40, 8'h00);
        @(posedge clk);
        bits(1'b0, 1'b0);
        apb(1'b1, 8'h5c, 8'h02);
        @(posedge clk);
        bits(1'b1, 1'b0);
        tx1 <= 1'b0;
        rx1 <= 1'b1;
        rx2 <= 1'b1;
        repeat (2) @(posedge clk);
        bits(1'b0, 1'b0);
        rdc(8'h58, 8'h01, "usart1 flags");
        rdc(8'h40, 8'h03, "usart2 flags");
        tx1 <= 1'b1;
        rx1 <= 1'b0;
        rx2 <= 1'b0;
        wrc(8'h5c, 8'h00, 8'h00, "enables1 clear");
        wrc(8'h44, 8'h00, 8'h00, "enables2 clear");
        $display("test pending done");
    endtask
    task automatic t_portb();
        pins <= 8'h5a;
        repeat (8) @(posedge clk);
        rdc(8'h58, 8'h82, "port change");
        wrc(8'h58, 8'h00, 8'h82, "mismatch holds");
        rdc(8'h64, 8'h5a, "snapshot");
        wrc(8'h58, 8'h00, 8'h02, "port cleared");
        $display("test port done");
    endtask
    task automatic t_events();
        ev(0, 3'h2, 1'b0, 8'h58, 8'h42);
        ev(0, 3'h0, 1'b0, 8'h58, 8'h02);
        ev(1, 3'h0, 1'b0, 8'h58, 8'h42);
        ev(1, 3'h2, 1'b0, 8'h58, 8'h02);
        ev(2, 3'h0, 1'b0, 8'h58, 8'h22);
        ev(3, 3'h0, 1'b0, 8'h58, 8'h12);
        ev(3, 3'h4, 1'b0, 8'h58, 8'h02);
        ev(4, 3'h4, 1'b0, 8'h58, 8'h12);
        ev(4, 3'h0, 1'b0, 8'h58, 8'h02);
        ev(5, 3'h0, 1'b0, 8'h58, 8'h06);
        ev(6, 3'h0, 1'b0, 8'h58, 8'h0a);
        ev(7, 3'h0, 1'b0, 8'h40, 8'h06);
        ev(8, 3'h0, 1'b0, 8'h40, 8'h0a);
        ev(9, 3'h0, 1'b0, 8'h40, 8'h82);
        ev(10, 3'h0, 1'b1, 8'h40, 8'h82);
        ev(10, 3'h0, 1'b0, 8'h40, 8'h02);
        ev(11, 3'h0, 1'b1, 8'h40, 8'h82);
        ev(12, 3'h0, 1'b1, 8'h40, 8'h42);
        ev(12, 3'h0, 1'b0, 8'h40, 8'h02);
        ev(13, 3'h0, 1'b0, 8'h40, 8'h22);
        $display("test events done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_pend();
        t_portb();
        t_events();
        end_of_test();
    end
endmodule
`default_nettype wire
